// [cfgm_consts.svh]
// constants for the trim configuration word map
`ifndef CFGM_CONSTS_SVH
`define CFGM_CONSTS_SVH

`define CFGM_WORD_W       10
`define CFGM_NUM_WORDS    10
`define CFGM_FIRST_USED   4
`define CFGM_STREAM_BITS  60
`define CFGM_COUNT_W      6
`define CFGM_SYNC_STAGES  2

`define CFGM_ADDR_BALANCE_TRIM   4
`define CFGM_ADDR_FB_BALANCE     5
`define CFGM_ADDR_RANGE_FB       6
`define CFGM_ADDR_OFFSET_FILTER  7
`define CFGM_ADDR_GAIN_TRIM      8
`define CFGM_ADDR_BIAS_OSC       9

`define CFGM_MASK_UNUSED  10'h000
`define CFGM_MASK_W4      10'h3fc
`define CFGM_MASK_W5      10'h3ff
`define CFGM_MASK_W6      10'h17f
`define CFGM_MASK_W7      10'h3fe
`define CFGM_MASK_W8      10'h1ff
`define CFGM_MASK_W9      10'h3ff

`define CFGM_NV_RESET     10'h000
`define CFGM_STREAM_RESET 60'h000_0000_0000_0000

`define CFGM_W9_IREF_LSB    7
`define CFGM_W9_VREF_LSB    3
`define CFGM_W8_GAIN_LSB    1
`define CFGM_W8_OFF0_POS    0
`define CFGM_W7_OFF_LSB     6
`define CFGM_W7_LEVEL_POS   5
`define CFGM_W7_FILTER_LSB  1
`define CFGM_W6_RANGE_POS   8
`define CFGM_W6_FB_LSB      0
`define CFGM_W5_FB_LSB      7
`define CFGM_W5_BAL_LSB     0
`define CFGM_W4_BAL_LSB     8
`define CFGM_W4_TRIM_LSB    2

`define CFGM_VREF_NOMINAL   4'h8
`define CFGM_IREF_NOMINAL   3'h6

`endif

// [cfgm_pkg.sv]
// types for the trim configuration word map
package cfgm_pkg;

	typedef enum logic [1:0] {
		cfgm_osc_nominal,
		cfgm_osc_raise,
		cfgm_osc_lower
	} cfgm_osc_dir_type;

	typedef enum logic [1:0] {
		cfgm_run,
		cfgm_held,
		cfgm_reload
	} cfgm_state_type;

endpackage

// [cfgm_pin_sync.sv]
// two flip-flop synchronisers for the programming pins
`timescale 1ns/1ps
module cfgm_pin_sync #(
	parameter int               WIDTH      = 5,
	parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			always_ff @(posedge clk) begin
				// reset to the pin's idle level, so no false edge follows reset
				if (reset) begin
					meta_q      <= IDLE_LEVEL[i];
					pin_sync[i] <= IDLE_LEVEL[i];
				end else begin
					meta_q      <= pin_in[i];
					pin_sync[i] <= meta_q;
				end
			end
		end
	endgenerate

endmodule // cfgm_pin_sync

// [cfgm_word_map.sv]
// serial programming link, volatile and nonvolatile trim words, field decode
//
// Notes on behaviour
// - hold current, voltage and oscillator trim fields
// - hold buffer, filter and capacitor trim fields
// - word 9: current, voltage, reversed oscillator trim
// - word 7: offset bits, level select, filter code
// - word 6: gain range, feedback bits 9..3
// - word 5: feedback bits 2..0, balance bits 8..2
// - word 4: balance bits 1..0, reversed trim cap
// - words 0..3 and spare bits carry nothing
// - voltage trim 0000 max up, 1000 nominal
// - current trim 000 lowest, 110 nominal, 111 highest
// - oscillator trim decodes nominal, raise or lower
// - 60-bit stream shifts in bit 0 first
// - reset release reloads volatile from nonvolatile words
// - data captured on serial strobe rising edge
// - select high loads volatile words directly
`include "cfgm_consts.svh"
`timescale 1ns/1ps
module cfgm_word_map (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        chip_reset_n,
	input  wire logic        direct_program_select,
	input  wire logic        serial_clock_in,
	input  wire logic        serial_data_in,
	input  wire logic        program_write_line,
	output logic             readback_line,
	output logic [2:0]       current_ref_trim,
	output logic [3:0]       voltage_ref_trim,
	output logic [2:0]       osc_trim,
	output logic [7:0]       gain_trim,
	output logic [4:0]       offset_trim,
	output logic             output_level_select,
	output logic [3:0]       filter_bandwidth_code,
	output logic             buffer_gain_range,
	output logic [9:0]       feedback_cap_code,
	output logic [8:0]       balance_cap_code,
	output logic [5:0]       trim_cap_code,
	output logic signed [4:0] voltage_adjust_steps,
	output logic signed [3:0] current_adjust_steps,
	output cfgm_pkg::cfgm_osc_dir_type osc_direction,
	output logic [1:0]       osc_step,
	output logic             frame_complete
);

	localparam int WW = `CFGM_WORD_W;
	localparam int NB = `CFGM_STREAM_BITS;

	logic [4:0]        pins_raw;
	logic [4:0]        pins_sync;
	logic              strobe_s;
	logic              data_s;
	logic              select_s;
	logic              write_s;
	logic              rst_n_s;
	logic              strobe_prev_q;
	logic              select_prev_q;
	logic              write_prev_q;
	logic              rst_n_prev_q;
	logic              strobe_rise;
	logic              select_edge;
	logic              write_rise;
	logic              rst_release;
	logic [NB-1:0]     shift_q;
	logic [NB-1:0]     shift_d;
	logic [`CFGM_COUNT_W-1:0] count_q;
	logic              full_q;
	logic [NB-1:0]     volatile_q;
	logic [WW-1:0]     nv_q [`CFGM_FIRST_USED:`CFGM_NUM_WORDS-1];
	logic [NB-1:0]     nv_stream;
	logic [`CFGM_COUNT_W-1:0] read_ptr_q;
	cfgm_pkg::cfgm_state_type state_q;
	logic [WW-1:0]     w4;
	logic [WW-1:0]     w5;
	logic [WW-1:0]     w6;
	logic [WW-1:0]     w7;
	logic [WW-1:0]     w8;
	logic [WW-1:0]     w9;
	logic [2:0]        osc_raw;
	logic [7:0]        gain_raw;
	logic [5:0]        trim_raw;

	// spare bit positions forced to zero on every path into storage
	function automatic logic [NB-1:0] mask_stream(input logic [NB-1:0] s);
		logic [NB-1:0] m;
		m = {`CFGM_MASK_W9, `CFGM_MASK_W8, `CFGM_MASK_W7,
			`CFGM_MASK_W6, `CFGM_MASK_W5, `CFGM_MASK_W4};
		return s & m;
	endfunction

	function automatic logic [WW-1:0] word_mask(input int addr);
		logic [WW-1:0] m;
		m = `CFGM_MASK_UNUSED;
		unique case (addr)
			`CFGM_ADDR_BALANCE_TRIM:  m = `CFGM_MASK_W4;
			`CFGM_ADDR_FB_BALANCE:    m = `CFGM_MASK_W5;
			`CFGM_ADDR_RANGE_FB:      m = `CFGM_MASK_W6;
			`CFGM_ADDR_OFFSET_FILTER: m = `CFGM_MASK_W7;
			`CFGM_ADDR_GAIN_TRIM:     m = `CFGM_MASK_W8;
			`CFGM_ADDR_BIAS_OSC:      m = `CFGM_MASK_W9;
			default:                  m = `CFGM_MASK_UNUSED;
		endcase
		return m;
	endfunction

	assign pins_raw = {chip_reset_n, program_write_line, direct_program_select,
		serial_data_in, serial_clock_in};

	// chip reset pin idles high; the other pins idle low
	cfgm_pin_sync #(
		.WIDTH      (5),
		.IDLE_LEVEL (5'h10)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.pin_in   (pins_raw),
		.pin_sync (pins_sync)
	);

	assign strobe_s = pins_sync[0];
	assign data_s   = pins_sync[1];
	assign select_s = pins_sync[2];
	assign write_s  = pins_sync[3];
	assign rst_n_s  = pins_sync[4];

	always_ff @(posedge clk) begin
		if (reset) begin
			strobe_prev_q <= 1'b0;
			select_prev_q <= 1'b0;
			write_prev_q  <= 1'b0;
			rst_n_prev_q  <= 1'b1;
		end else begin
			strobe_prev_q <= strobe_s;
			select_prev_q <= select_s;
			write_prev_q  <= write_s;
			rst_n_prev_q  <= rst_n_s;
		end
	end

	// data and strobe share the same sync delay, so data is stable here
	assign strobe_rise = strobe_s & ~strobe_prev_q;
	assign select_edge = select_s ^ select_prev_q;
	assign write_rise  = write_s & ~write_prev_q;
	assign rst_release = rst_n_s & ~rst_n_prev_q;

	// new bit enters at the top, so bit 0 ends at the bottom after 60 shifts
	assign shift_d = {data_s, shift_q[NB-1:1]};

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_q <= `CFGM_STREAM_RESET;
		end else if (strobe_rise && rst_n_s && !full_q) begin
			shift_q <= shift_d;
		end
	end

	// frame restarts on any select change, so a half frame is discarded
	always_ff @(posedge clk) begin
		if (reset) begin
			count_q <= '0;
			full_q  <= 1'b0;
		end else if (!rst_n_s || select_edge || write_rise) begin
			count_q <= '0;
			full_q  <= 1'b0;
		end else if (strobe_rise && !full_q) begin
			if (count_q == `CFGM_COUNT_W'(NB - 1)) begin
				count_q <= '0;
				full_q  <= 1'b1;
			end else begin
				count_q <= count_q + `CFGM_COUNT_W'(1);
			end
		end
	end

	assign frame_complete = full_q;

	// reset sequencer: hold while the chip reset pin is low, reload on release
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= cfgm_pkg::cfgm_reload;
		end else begin
			unique case (state_q)
				cfgm_pkg::cfgm_run: begin
					if (!rst_n_s) begin
						state_q <= cfgm_pkg::cfgm_held;
					end
				end
				cfgm_pkg::cfgm_held: begin
					if (rst_release) begin
						state_q <= cfgm_pkg::cfgm_reload;
					end
				end
				cfgm_pkg::cfgm_reload: begin
					state_q <= rst_n_s ? cfgm_pkg::cfgm_run : cfgm_pkg::cfgm_held;
				end
			endcase
		end
	end

	// nonvolatile store: words 0..3 carry nothing, so they get no flops
	genvar a;
	generate
		for (a = `CFGM_FIRST_USED; a < `CFGM_NUM_WORDS; a++) begin : g_nv
			always_ff @(posedge clk) begin
				if (reset) begin
					nv_q[a] <= `CFGM_NV_RESET;
				end else if (write_rise && full_q) begin
					nv_q[a] <= shift_q[(a - `CFGM_FIRST_USED) * WW +: WW] & word_mask(a);
				end
			end
		end
	endgenerate

	assign nv_stream = {nv_q[9], nv_q[8], nv_q[7], nv_q[6], nv_q[5], nv_q[4]};

	// volatile words: direct load on frame end, reload after chip reset
	always_ff @(posedge clk) begin
		if (reset) begin
			volatile_q <= `CFGM_STREAM_RESET;
		end else if (state_q == cfgm_pkg::cfgm_reload) begin
			volatile_q <= mask_stream(nv_stream);
		end else if (select_s && rst_n_s && strobe_rise && !full_q
			&& count_q == `CFGM_COUNT_W'(NB - 1)) begin
			volatile_q <= mask_stream(shift_d);
		end
	end

	// read-back walks the volatile words bit 0 first, one bit per strobe
	always_ff @(posedge clk) begin
		if (reset || !rst_n_s || select_edge) begin
			read_ptr_q <= '0;
		end else if (strobe_rise && !select_s) begin
			if (read_ptr_q == `CFGM_COUNT_W'(NB - 1)) begin
				read_ptr_q <= '0;
			end else begin
				read_ptr_q <= read_ptr_q + `CFGM_COUNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			readback_line <= 1'b0;
		end else begin
			readback_line <= volatile_q[read_ptr_q];
		end
	end

	assign w4 = volatile_q[0*WW +: WW];
	assign w5 = volatile_q[1*WW +: WW];
	assign w6 = volatile_q[2*WW +: WW];
	assign w7 = volatile_q[3*WW +: WW];
	assign w8 = volatile_q[4*WW +: WW];
	assign w9 = volatile_q[5*WW +: WW];

	// reversed fields: field bit i sits at word position (top - i)
	genvar b;
	generate
		for (b = 0; b < 3; b++) begin : g_osc
			assign osc_raw[b] = w9[2 - b];
		end
		for (b = 0; b < 8; b++) begin : g_gain
			assign gain_raw[b] = w8[`CFGM_W8_GAIN_LSB + 7 - b];
		end
		for (b = 0; b < 6; b++) begin : g_trim
			assign trim_raw[b] = w4[`CFGM_W4_TRIM_LSB + 5 - b];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) begin
			current_ref_trim <= 3'h0;
			voltage_ref_trim <= 4'h0;
			osc_trim         <= 3'h0;
		end else begin
			current_ref_trim <= w9[`CFGM_W9_IREF_LSB +: 3];
			voltage_ref_trim <= w9[`CFGM_W9_VREF_LSB +: 4];
			osc_trim         <= osc_raw;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gain_trim             <= 8'h00;
			offset_trim           <= 5'h00;
			output_level_select   <= 1'b0;
			filter_bandwidth_code <= 4'h0;
		end else begin
			gain_trim             <= gain_raw;
			offset_trim           <= {w7[`CFGM_W7_OFF_LSB], w7[`CFGM_W7_OFF_LSB + 1],
				w7[`CFGM_W7_OFF_LSB + 2], w7[`CFGM_W7_OFF_LSB + 3],
				w8[`CFGM_W8_OFF0_POS]};
			output_level_select   <= w7[`CFGM_W7_LEVEL_POS];
			filter_bandwidth_code <= w7[`CFGM_W7_FILTER_LSB +: 4];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			buffer_gain_range <= 1'b0;
			feedback_cap_code <= 10'h000;
			balance_cap_code  <= 9'h000;
			trim_cap_code     <= 6'h00;
		end else begin
			buffer_gain_range <= w6[`CFGM_W6_RANGE_POS];
			feedback_cap_code <= {w6[`CFGM_W6_FB_LSB +: 7], w5[`CFGM_W5_FB_LSB +: 3]};
			balance_cap_code  <= {w5[`CFGM_W5_BAL_LSB +: 7], w4[`CFGM_W4_BAL_LSB +: 2]};
			trim_cap_code     <= trim_raw;
		end
	end

	// adjust steps are relative to nominal: positive means larger output
	always_ff @(posedge clk) begin
		if (reset) begin
			voltage_adjust_steps <= 5'sh00;
			current_adjust_steps <= 4'sh0;
		end else begin
			voltage_adjust_steps <= 5'($signed({1'b0, `CFGM_VREF_NOMINAL})
				- $signed({1'b0, w9[`CFGM_W9_VREF_LSB +: 4]}));
			current_adjust_steps <= 4'($signed({1'b0, w9[`CFGM_W9_IREF_LSB +: 3]})
				- $signed({1'b0, `CFGM_IREF_NOMINAL}));
		end
	end

	// code 100 is a second nominal; larger step means larger change
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_direction <= cfgm_pkg::cfgm_osc_nominal;
			osc_step      <= 2'h0;
		end else if (osc_raw[1:0] == 2'h0) begin
			osc_direction <= cfgm_pkg::cfgm_osc_nominal;
			osc_step      <= 2'h0;
		end else begin
			osc_direction <= osc_raw[2] ? cfgm_pkg::cfgm_osc_lower
				: cfgm_pkg::cfgm_osc_raise;
			osc_step      <= osc_raw[1:0];
		end
	end

endmodule // cfgm_word_map

// [cfgm_word_map_asserts.sv]
// concurrent checks on the trim word map ports
`timescale 1ns/1ps
module cfgm_word_map_asserts (
	input wire logic                       clk,
	input wire logic                       reset,
	input wire logic                       chip_reset_n,
	input wire logic                       direct_program_select,
	input wire logic                       serial_clock_in,
	input wire logic                       program_write_line,
	input wire logic [2:0]                 current_ref_trim,
	input wire logic [3:0]                 voltage_ref_trim,
	input wire logic [2:0]                 osc_trim,
	input wire logic [7:0]                 gain_trim,
	input wire logic [9:0]                 feedback_cap_code,
	input wire logic signed [4:0]          voltage_adjust_steps,
	input wire logic signed [3:0]          current_adjust_steps,
	input wire cfgm_pkg::cfgm_osc_dir_type osc_direction,
	input wire logic [1:0]                 osc_step,
	input wire logic                       frame_complete
);
	logic [2:0] up_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// decode checks wait out the reload that follows reset
	always_ff @(posedge clk) begin
		if (reset)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	property p_reset_clear;
		$past(reset) |-> gain_trim == 8'h00 && voltage_adjust_steps == 5'sh00 && !frame_complete;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not clear after reset");
	property p_vadj;
		up_q == 3'h7 && $stable(voltage_ref_trim)
			|-> voltage_adjust_steps == 5'sh08 - $signed({1'b0, voltage_ref_trim});
	endproperty
	a_vadj: assert property (p_vadj)
		else $error("voltage adjust does not follow trim");
	property p_cadj;
		up_q == 3'h7 && $stable(current_ref_trim)
			|-> current_adjust_steps == $signed({1'b0, current_ref_trim}) - 4'sh6;
	endproperty
	a_cadj: assert property (p_cadj)
		else $error("current adjust does not follow trim");
	property p_osc_dir;
		up_q == 3'h7 && $stable(osc_trim) |-> osc_direction == (osc_trim[1:0] == 2'h0 ?
			cfgm_pkg::cfgm_osc_nominal : osc_trim[2] ? cfgm_pkg::cfgm_osc_lower
			: cfgm_pkg::cfgm_osc_raise);
	endproperty
	a_osc_dir: assert property (p_osc_dir)
		else $error("oscillator direction wrong");
	property p_osc_step;
		up_q == 3'h7 && $stable(osc_trim) |-> osc_step == osc_trim[1:0];
	endproperty
	a_osc_step: assert property (p_osc_step)
		else $error("oscillator step wrong");
	property p_strobe;
		$rose(frame_complete) |-> $past(serial_clock_in, 2);
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("frame ended away from a strobe rise");
	property p_load_src;
		up_q == 3'h7 && $changed({gain_trim, feedback_cap_code, voltage_ref_trim})
			|-> (frame_complete && direct_program_select) || !$past(chip_reset_n, 7);
	endproperty
	a_load_src: assert property (p_load_src)
		else $error("fields changed without a load");
	property p_frame_hold;
		(frame_complete && chip_reset_n && !program_write_line
			&& $stable(direct_program_select))[*4] |=> frame_complete;
	endproperty
	a_frame_hold: assert property (p_frame_hold)
		else $error("frame flag dropped without cause");
endmodule // cfgm_word_map_asserts

bind cfgm_word_map cfgm_word_map_asserts cfgm_word_map_asserts_i (.clk, .reset,
	.chip_reset_n, .direct_program_select, .serial_clock_in, .program_write_line,
	.current_ref_trim, .voltage_ref_trim, .osc_trim, .gain_trim, .feedback_cap_code,
	.voltage_adjust_steps, .current_adjust_steps, .osc_direction, .osc_step,
	.frame_complete);

// [cfgm_prog_model.sv]
// external serial programmer driving the reset, select and link pins
`timescale 1ns/1ps
module cfgm_prog_model #(
	parameter int SEL_DELAY = 12,
	parameter int RST_LEN   = 20
) (
	input  wire logic clk,
	input  wire logic readback_line,
	output logic      chip_reset_n,
	output logic      direct_program_select,
	output logic      serial_clock_in,
	output logic      serial_data_in,
	output logic      program_write_line
);
	initial begin
		chip_reset_n = 1'b1;
		direct_program_select = 1'b0;
		serial_clock_in = 1'b0;
		serial_data_in = 1'b0;
		program_write_line = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// 320 ns strobe; clock rests low between frames, as its pull-down leaves it
	// data leads the rise by two clocks so it never races the strobe
	task automatic strobe(input logic b);
		serial_data_in = b;
		idle(2);
		serial_clock_in = 1'b1;
		idle(4);
		serial_clock_in = 1'b0;
		idle(2);
	endtask
	task automatic send(input logic [59:0] s, input logic commit);
		direct_program_select = 1'b0;
		idle(4);
		direct_program_select = 1'b1;
		idle(SEL_DELAY);
		for (int k = 0; k < 60; k++)
			strobe(s[k]);
		serial_data_in = 1'b0;
		if (commit) begin
			program_write_line = 1'b1;
			idle(8);
			program_write_line = 1'b0;
			idle(4);
		end
	endtask
	task automatic pulse_reset;
		chip_reset_n = 1'b0;
		idle(RST_LEN);
		chip_reset_n = 1'b1;
		idle(10);
	endtask
	// select edge clears the pointer, so the first sample is bit 0
	task automatic read(output logic [59:0] r);
		direct_program_select = 1'b0;
		idle(6);
		for (int k = 0; k < 60; k++) begin
			r[k] = readback_line;
			strobe(1'b0);
		end
	endtask
endmodule // cfgm_prog_model

// [cfgm_word_map_tb_top.sv]
// self-checking bench for the trim configuration word map
`timescale 1ns/1ps
module cfgm_word_map_tb_top;
	localparam logic [43:0] PAT = 44'h96a_53c0_fe1d;
	// rows: current, voltage, osc trim beside voltage adjust, current adjust, direction
	localparam logic [20:0] ROWS [8] = '{
		{3'h0, 4'h0, 3'h0, 5'h08, 4'ha, 2'h0}, {3'h6, 4'h8, 3'h1, 5'h00, 4'h0, 2'h1},
		{3'h7, 4'hf, 3'h2, 5'h19, 4'h1, 2'h1}, {3'h1, 4'h1, 3'h3, 5'h07, 4'hb, 2'h1},
		{3'h2, 4'h7, 3'h4, 5'h01, 4'hc, 2'h0}, {3'h3, 4'h9, 3'h5, 5'h1f, 4'hd, 2'h2},
		{3'h4, 4'he, 3'h6, 5'h1a, 4'he, 2'h2}, {3'h5, 4'h3, 3'h7, 5'h05, 4'hf, 2'h2}};
	logic                       clk;
	logic                       reset;
	logic                       chip_reset_n;
	logic                       direct_program_select;
	logic                       serial_clock_in;
	logic                       serial_data_in;
	logic                       program_write_line;
	logic                       readback_line;
	logic [2:0]                 current_ref_trim;
	logic [3:0]                 voltage_ref_trim;
	logic [2:0]                 osc_trim;
	logic [7:0]                 gain_trim;
	logic [4:0]                 offset_trim;
	logic                       output_level_select;
	logic [3:0]                 filter_bandwidth_code;
	logic                       buffer_gain_range;
	logic [9:0]                 feedback_cap_code;
	logic [8:0]                 balance_cap_code;
	logic [5:0]                 trim_cap_code;
	logic signed [4:0]          voltage_adjust_steps;
	logic signed [3:0]          current_adjust_steps;
	cfgm_pkg::cfgm_osc_dir_type osc_direction;
	logic [1:0]                 osc_step;
	logic                       frame_complete;
	int                         miscompares;
	int                         n_tests;
	logic [53:0]                x;
	logic [53:0]                x0;
	logic [59:0]                rb;
	cfgm_word_map cfgm_word_map_i (.clk, .reset, .chip_reset_n, .direct_program_select,
		.serial_clock_in, .serial_data_in, .program_write_line, .readback_line,
		.current_ref_trim, .voltage_ref_trim, .osc_trim, .gain_trim, .offset_trim,
		.output_level_select, .filter_bandwidth_code, .buffer_gain_range,
		.feedback_cap_code, .balance_cap_code, .trim_cap_code, .voltage_adjust_steps,
		.current_adjust_steps, .osc_direction, .osc_step, .frame_complete);
	cfgm_prog_model cfgm_prog_model_i (.clk, .readback_line, .chip_reset_n,
		.direct_program_select, .serial_clock_in, .serial_data_in, .program_write_line);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// spare positions carry sp so a design that uses them shows up
	function automatic logic [59:0] pack(input logic [53:0] f, input logic sp);
		logic [7:0] g;
		logic [3:0] o4;
		logic [5:0] t;
		g = {<<{f[43:36]}};
		o4 = {<<{f[35:32]}};
		t = {<<{f[5:0]}};
		return {f[53:47], f[44], f[45], f[46], sp, g, f[31], o4, f[30:26], sp,
			sp, f[25], sp, f[24:18], f[17:6], t, sp, sp};
	endfunction
	task automatic chk_fields(input logic [53:0] f, input logic [20:0] w);
		chk(current_ref_trim, f[53:51]);
		chk(voltage_ref_trim, f[50:47]);
		chk(osc_trim, f[46:44]);
		chk(gain_trim, f[43:36]);
		chk(offset_trim, f[35:31]);
		chk({output_level_select, filter_bandwidth_code}, f[30:26]);
		chk(buffer_gain_range, f[25]);
		chk(feedback_cap_code, f[24:15]);
		chk(balance_cap_code, f[14:6]);
		chk(trim_cap_code, f[5:0]);
		chk({voltage_adjust_steps, current_adjust_steps, osc_direction, osc_step},
			{w[10:0], f[45:44]});
	endtask
	task automatic chk_reset;
		repeat (6) @(negedge clk);
		chk(frame_complete, 1'b0);
		chk_fields(54'h0, ROWS[0]);
	endtask
	task automatic wait_frame;
		int n;
		n = 0;
		while (frame_complete !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk(frame_complete, 1'b1);
		if (n == 20)
			close_out;
		repeat (3) @(negedge clk);
	endtask
	initial begin
		reset = 1'b1;
		miscompares = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk_reset;
		for (int k = 0; k < 8; k++) begin
			x = {ROWS[k][20:11], (PAT << (5 * k)) | (PAT >> (44 - 5 * k))};
			cfgm_prog_model_i.send(pack(x, 1'b1), 1'b0);
			wait_frame;
			chk_fields(x, ROWS[k]);
		end
		for (int k = 0; k < 3; k++)
			cfgm_prog_model_i.strobe(1'b1);
		chk_fields(x, ROWS[7]);
		cfgm_prog_model_i.read(rb);
		chk(rb, pack(x, 1'b0));
		x0 = {ROWS[2][20:11], ~PAT};
		cfgm_prog_model_i.send(pack(x0, 1'b1), 1'b1);
		cfgm_prog_model_i.send(pack(x, 1'b1), 1'b0);
		wait_frame;
		cfgm_prog_model_i.pulse_reset;
		chk_fields(x0, ROWS[2]);
		cfgm_prog_model_i.read(rb);
		chk(rb, pack(x0, 1'b0));
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		chk_reset;
		close_out;
	end
endmodule // cfgm_word_map_tb_top
